/* core/addr_mode_cond_decode.sv */
`timescale 1ns/1ns
`include "addr_mode_cond_decode_defines.svh"
// What this block does
// - User-privilege transfers: offset or post-indexed only.
// - Scaled index: five-bit shift or carry rotate.
// - Halfword/signed: 8-bit immediate or plain index.
// - Load stack aliases map to four sequences.
// - Store stack aliases map to four sequences.
// - Coprocessor offset is 8-bit immediate times four.
// - Operand two: immediate, immediate shift, register shift.
// - Rotate through carry by one place.
// - Field suffixes set control, extension, status, flags.
// - Single-flag conditions and unsigned-higher.
// - Signed at-least passes when N equals V.
// - Signed below passes when N differs V.
// - Signed above needs Z clear, N equals V.
// - Always code executes whatever the flags.
module addr_mode_cond_decode (
	input  wire logic        i_clk_sys,          // System clock, 250 MHz.
	input  wire logic        i_sys_rst,          // Synchronous reset, active high.
	input  wire logic [5:0]  i_avs_address,      // Byte address.
	input  wire logic        i_avs_read,         // Read request.
	input  wire logic        i_avs_write,        // Write request.
	input  wire logic [31:0] i_avs_writedata,    // Write data.
	input  wire logic [3:0]  i_avs_byteenable,   // Byte lanes of a write.
	output logic      [31:0] o_avs_readdata,     // Read data.
	output logic             o_avs_waitrequest,  // Stall of the request.
	output logic             o_cond_pass         // Current condition result.
);
	// Merges the enabled byte lanes of a write into the old word.
	function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
		input logic [3:0] be);
		logic [31:0] m;
		m = old_w;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) m[8*i +: 8] = new_w[8*i +: 8];
		end
		return m;
	endfunction : merge

	// Adds or subtracts an offset according to the up bit.
	function automatic logic [31:0] step(input logic [31:0] base, input logic [31:0] ofs,
		input logic up);
		return up ? base + ofs : base - ofs;
	endfunction : step

	// Gives the stack alias of a block sequence for a load or a store.
	function automatic addr_mode_cond_decode_pkg::stack_type_t stack_alias(
		input addr_mode_cond_decode_pkg::block_mode_t mode, input logic load);
		addr_mode_cond_decode_pkg::stack_type_t s;
		case (mode)
			addr_mode_cond_decode_pkg::increment_after:
				s = load ? addr_mode_cond_decode_pkg::full_descending
				         : addr_mode_cond_decode_pkg::empty_ascending;
			addr_mode_cond_decode_pkg::increment_before:
				s = load ? addr_mode_cond_decode_pkg::empty_descending
				         : addr_mode_cond_decode_pkg::full_ascending;
			addr_mode_cond_decode_pkg::decrement_after:
				s = load ? addr_mode_cond_decode_pkg::full_ascending
				         : addr_mode_cond_decode_pkg::empty_descending;
			addr_mode_cond_decode_pkg::decrement_before:
				s = load ? addr_mode_cond_decode_pkg::empty_ascending
				         : addr_mode_cond_decode_pkg::full_descending;
			default: s = addr_mode_cond_decode_pkg::full_descending;
		endcase
		return s;
	endfunction : stack_alias

	// Software-written words.
	logic [31:0] instr_q, instr_d;   // Instruction under decode.
	logic [3:0]  flags_q, flags_d;   // N, Z, C, V.
	logic [31:0] rm_q, rm_d;         // Index or second-operand register.
	logic [31:0] rs_q, rs_d;         // Register holding a shift distance.
	logic [31:0] rn_q, rn_d;         // Base register.
	logic        ctrl_q, ctrl_d;     // Set: decode as a user-privilege transfer.

	// Decode results, held in flops for the bus to read.
	logic [31:0] status_q;   // Packed decode status.
	logic [31:0] opnd2_q;    // Shifter result.
	logic [31:0] addr_q;     // Transfer address.
	logic [31:0] wbaddr_q;   // Base value written back.
	logic [31:0] offset_q;   // Offset before add or subtract.

	// Bus handshake state.
	logic        ack_q;        // Second cycle of an access.
	logic [31:0] readdata_q;   // Captured read word.

	// Field views of the instruction.
	wire [3:0]  cond_f  = instr_q[31:28];
	wire        pre_f   = instr_q[24];
	wire        up_f    = instr_q[23];
	wire        wb_f    = instr_q[21];
	wire        load_f  = instr_q[20];
	wire [4:0]  imm5_f  = instr_q[11:7];
	wire [1:0]  kind_f  = instr_q[6:5];
	wire        regsh_f = instr_q[4];

	// Instruction class decode.
	wire is_half  = (instr_q[27:25] == 3'h0) && instr_q[7] && instr_q[4]
	                && (instr_q[6:5] != 2'h0);
	wire is_msr   = (instr_q[27:26] == 2'h0) && (instr_q[24:23] == 2'h2)
	                && (instr_q[21:20] == 2'h2);
	wire is_dp    = (instr_q[27:26] == 2'h0) && !is_half && !is_msr;
	wire is_ldst  = (instr_q[27:26] == 2'h1);
	wire is_block = (instr_q[27:25] == 3'h4);
	wire is_cop   = (instr_q[27:25] == 3'h6);

	// Operand two immediate: eight bits rotated right by twice a nibble.
	wire [4:0]  imm_rot = {instr_q[11:8], 1'b0};
	wire [31:0] imm_val = ({24'h0, instr_q[7:0]} >> imm_rot)
	                      | ({24'h0, instr_q[7:0]} << (6'h20 - {1'b0, imm_rot}));
	wire        imm_c   = (imm_rot == 5'h0) ? flags_q[`FLAG_C] : imm_val[31];
	wire        dp_imm  = is_dp && instr_q[25];

	// An immediate distance of zero means 32 for right shifts, and a
	// zero rotate means the one-place rotate through carry.
	wire by_reg   = is_dp && regsh_f;
	wire zero_imm = (imm5_f == 5'h0) && !by_reg;
	wire [7:0] sh_amt = by_reg ? rs_q[7:0]
	                  : (zero_imm && (kind_f != 2'h0)) ? 8'h20 : {3'h0, imm5_f};
	wire addr_mode_cond_decode_pkg::shift_kind_t sh_kind =
		(zero_imm && (kind_f == 2'h3)) ? addr_mode_cond_decode_pkg::rotate_through_carry
		: addr_mode_cond_decode_pkg::shift_kind_t'({1'b0, kind_f});

	// Shift request to the barrel shifter.
	shift_if sh_bus ();
	assign sh_bus.value    = rm_q;
	assign sh_bus.amount   = sh_amt;
	assign sh_bus.kind     = sh_kind;
	assign sh_bus.carry_in = flags_q[`FLAG_C];

	operand_shifter u_shifter (
		.sh (sh_bus.unit)
	);

	// Condition evaluation on the current flags.
	wire cond_ok;
	cond_check u_cond (
		.i_cond  (addr_mode_cond_decode_pkg::cond_code_t'(cond_f)),
		.i_flags (flags_q),
		.o_pass  (cond_ok)
	);

	// Operand two: immediate, or the shifted register.
	wire [31:0] opnd2_d = dp_imm ? imm_val : sh_bus.result;
	wire        carry_d = dp_imm ? imm_c : sh_bus.carry_out;

	// Offset of each transfer class before the up bit is applied.
	wire [31:0] ofs_single = instr_q[25] ? sh_bus.result
	                       : {20'h0, instr_q[11:0]};
	wire [31:0] ofs_half   = instr_q[22] ? {24'h0, instr_q[11:8], instr_q[3:0]}
	                       : rm_q;
	wire [31:0] ofs_cop    = {22'h0, instr_q[7:0], 2'h0};
	wire [31:0] ofs_any    = is_ldst ? ofs_single : is_half ? ofs_half : ofs_cop;

	// Offset and indexed addressing shared by single, halfword and coprocessor.
	wire [31:0] idx_sum  = step(rn_q, ofs_any, up_f);
	wire [31:0] idx_addr = pre_f ? idx_sum : rn_q;
	wire        idx_wb   = !pre_f || wb_f;

	// A user-privilege transfer has no pre-indexed writeback form.
	wire single_ok = !(ctrl_q && pre_f && wb_f);
	// A halfword transfer with post-index and the writeback bit is not defined.
	wire half_ok   = pre_f || !wb_f;
	// A coprocessor transfer with neither index nor writeback is not a transfer.
	wire cop_ok    = pre_f || wb_f;

	// Block transfer: four bytes per listed register.
	logic [4:0] reg_cnt;
	always_comb begin
		reg_cnt = 5'h0;
		for (int i = 0; i < 16; i++) begin
			reg_cnt = reg_cnt + {4'h0, instr_q[i]};
		end
	end
	wire [31:0] blk_len  = {25'h0, reg_cnt, 2'h0};
	wire addr_mode_cond_decode_pkg::block_mode_t blk_mode =
		addr_mode_cond_decode_pkg::block_mode_t'({pre_f, up_f});
	wire [31:0] blk_wb   = step(rn_q, blk_len, up_f);
	wire [31:0] blk_addr =
		(blk_mode == addr_mode_cond_decode_pkg::increment_after)  ? rn_q
		: (blk_mode == addr_mode_cond_decode_pkg::increment_before) ? rn_q + 32'h4
		: (blk_mode == addr_mode_cond_decode_pkg::decrement_after)  ? blk_wb + 32'h4
		: blk_wb;
	wire addr_mode_cond_decode_pkg::stack_type_t blk_stack =
		stack_alias(blk_mode, load_f);

	// Status-register write mask: control, extension, status, flags.
	wire [3:0] psr_mask = is_msr ? {instr_q[16], instr_q[17], instr_q[18], instr_q[19]}
	                    : 4'h0;

	// Class and validity summary.
	wire addr_mode_cond_decode_pkg::form_t form =
		is_msr   ? addr_mode_cond_decode_pkg::form_status_write
		: is_half  ? addr_mode_cond_decode_pkg::form_halfword
		: is_dp    ? addr_mode_cond_decode_pkg::form_operand2
		: is_ldst  ? addr_mode_cond_decode_pkg::form_single
		: is_block ? addr_mode_cond_decode_pkg::form_block
		: is_cop   ? addr_mode_cond_decode_pkg::form_coproc
		: addr_mode_cond_decode_pkg::form_none;
	wire form_ok = is_ldst ? single_ok : is_half ? half_ok : is_cop ? cop_ok
	             : (form != addr_mode_cond_decode_pkg::form_none);
	wire is_idx  = is_ldst || is_half || is_cop;
	wire wb_en   = is_idx ? idx_wb : is_block ? wb_f : 1'b0;

	// Packed status word for software.
	wire [31:0] status_d = {15'h0, form, carry_d, psr_mask, blk_stack, blk_mode,
	                        up_f, pre_f, wb_en, form_ok, cond_ok};

	// Decode results are refreshed every clock from the written words.
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			status_q <= `RST_WORD;
			opnd2_q  <= `RST_WORD;
			addr_q   <= `RST_WORD;
			wbaddr_q <= `RST_WORD;
			offset_q <= `RST_WORD;
		end else begin
			status_q <= status_d;
			opnd2_q  <= opnd2_d;
			addr_q   <= is_block ? blk_addr : is_idx ? idx_addr : `RST_WORD;
			wbaddr_q <= is_block ? blk_wb : is_idx ? idx_sum : `RST_WORD;
			offset_q <= is_block ? blk_len : is_idx ? ofs_any : `RST_WORD;
		end
	end

	// Bus decode: every access waits one cycle, then completes.
	wire access  = i_avs_read || i_avs_write;
	wire do_wr   = i_avs_write && ack_q;
	wire hit_ins = (i_avs_address == `OFS_INSTR);
	wire hit_flg = (i_avs_address == `OFS_FLAGS);
	wire hit_rm  = (i_avs_address == `OFS_RM);
	wire hit_rs  = (i_avs_address == `OFS_RS);
	wire hit_rn  = (i_avs_address == `OFS_RN);
	wire hit_ctl = (i_avs_address == `OFS_CTRL);

	// Read selection; unmapped addresses read as zero.
	wire [31:0] rd_mux =
		hit_ins ? instr_q : hit_flg ? {28'h0, flags_q} : hit_rm ? rm_q
		: hit_rs ? rs_q : hit_rn ? rn_q : hit_ctl ? {31'h0, ctrl_q}
		: (i_avs_address == `OFS_STATUS) ? status_q
		: (i_avs_address == `OFS_OPND2)  ? opnd2_q
		: (i_avs_address == `OFS_ADDR)   ? addr_q
		: (i_avs_address == `OFS_WBADDR) ? wbaddr_q
		: (i_avs_address == `OFS_OFFSET) ? offset_q : `RST_WORD;

	// Next values of the writable words; unmapped writes are dropped.
	assign instr_d = (do_wr && hit_ins) ? merge(instr_q, i_avs_writedata, i_avs_byteenable)
	               : instr_q;
	assign flags_d = (do_wr && hit_flg && i_avs_byteenable[0]) ? i_avs_writedata[3:0]
	               : flags_q;
	assign rm_d    = (do_wr && hit_rm) ? merge(rm_q, i_avs_writedata, i_avs_byteenable)
	               : rm_q;
	assign rs_d    = (do_wr && hit_rs) ? merge(rs_q, i_avs_writedata, i_avs_byteenable)
	               : rs_q;
	assign rn_d    = (do_wr && hit_rn) ? merge(rn_q, i_avs_writedata, i_avs_byteenable)
	               : rn_q;
	assign ctrl_d  = (do_wr && hit_ctl && i_avs_byteenable[0]) ? i_avs_writedata[0]
	               : ctrl_q;

	// Writable words.
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			instr_q <= `RST_WORD;
			flags_q <= `RST_FLAGS;
			rm_q    <= `RST_WORD;
			rs_q    <= `RST_WORD;
			rn_q    <= `RST_WORD;
			ctrl_q  <= `RST_CTRL;
		end else begin
			instr_q <= instr_d;
			flags_q <= flags_d;
			rm_q    <= rm_d;
			rs_q    <= rs_d;
			rn_q    <= rn_d;
			ctrl_q  <= ctrl_d;
		end
	end

	// Handshake: read data is captured in the stall cycle and stands at
	// the completing edge.
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			ack_q      <= 1'b0;
			readdata_q <= `RST_WORD;
		end else begin
			ack_q <= access && !ack_q;
			if (i_avs_read && !ack_q) begin
				readdata_q <= rd_mux;
			end
		end
	end

	assign o_avs_waitrequest = access && !ack_q;
	assign o_avs_readdata    = readdata_q;
	assign o_cond_pass       = status_q[`ST_PASS];
endmodule : addr_mode_cond_decode

/* core/addr_mode_cond_decode_defines.svh */
`ifndef ADDR_MODE_COND_DECODE_DEFINES_SVH
`define ADDR_MODE_COND_DECODE_DEFINES_SVH
// Byte addresses of the software-visible words.
`define OFS_INSTR   6'h00
`define OFS_FLAGS   6'h04
`define OFS_RM      6'h08
`define OFS_RS      6'h0C
`define OFS_RN      6'h10
`define OFS_CTRL    6'h14
`define OFS_STATUS  6'h18
`define OFS_OPND2   6'h1C
`define OFS_ADDR    6'h20
`define OFS_WBADDR  6'h24
`define OFS_OFFSET  6'h28
// Reset values of the writable words.
`define RST_WORD    32'h0000_0000
`define RST_FLAGS   4'h0
`define RST_CTRL    1'h0
// Flag positions in the flags word: N, Z, C, V.
`define FLAG_N      3
`define FLAG_Z      2
`define FLAG_C      1
`define FLAG_V      0
// Field positions in the status word.
`define ST_PASS     0
`define ST_VALID    1
`define ST_WB       2
`define ST_PRE      3
`define ST_UP       4
`define ST_MODE_LO  5
`define ST_STACK_LO 7
`define ST_MASK_LO  9
`define ST_CARRY    13
`define ST_FORM_LO  14
`endif

/* core/addr_mode_cond_decode_pkg.sv */
package addr_mode_cond_decode_pkg;
	// Shift kinds applied to an index or second-operand register.
	typedef enum logic [2:0] {
		shift_left_logical   = 3'h0,
		shift_right_logical  = 3'h1,
		arith_right_shift    = 3'h2,
		rotate_right         = 3'h3,
		rotate_through_carry = 3'h4
	} shift_kind_t;
	// Condition suffix codes as held in the top nibble of an instruction.
	typedef enum logic [3:0] {
		zero_set_cond, zero_clear_cond, carry_set_cond, carry_clear_cond,
		negative_cond, nonneg_cond, overflow_set_cond, overflow_clear_cond,
		unsigned_above_cond, unsigned_at_most_cond, signed_at_least_cond,
		signed_below_cond, signed_above_cond, signed_at_most_cond,
		never_skip_cond, cond_reserved
	} cond_code_t;
	// Block transfer sequences, coded as the before and up bits.
	typedef enum logic [1:0] {
		decrement_after  = 2'h0,
		increment_after  = 2'h1,
		decrement_before = 2'h2,
		increment_before = 2'h3
	} block_mode_t;
	// Stack-type names that alias the block transfer sequences.
	typedef enum logic [1:0] {
		full_descending, empty_descending, full_ascending, empty_ascending
	} stack_type_t;
	// Instruction classes that this decoder recognises.
	typedef enum logic [2:0] {
		form_none, form_operand2, form_single, form_halfword,
		form_block, form_coproc, form_status_write
	} form_t;
endpackage : addr_mode_cond_decode_pkg

/* core/cond_check.sv */
`timescale 1ns/1ns
`include "addr_mode_cond_decode_defines.svh"
// Decides whether a condition suffix passes on the N, Z, C and V flags.
module cond_check (
	input  wire addr_mode_cond_decode_pkg::cond_code_t i_cond,   // Suffix code.
	input  wire logic [3:0]                             i_flags,  // N, Z, C, V.
	output logic                                        o_pass    // Condition holds.
);
	wire n = i_flags[`FLAG_N];
	wire z = i_flags[`FLAG_Z];
	wire c = i_flags[`FLAG_C];
	wire v = i_flags[`FLAG_V];

	// One branch per suffix; the reserved code never passes.
	always_comb begin
		case (i_cond)
			addr_mode_cond_decode_pkg::zero_set_cond:         o_pass = z;
			addr_mode_cond_decode_pkg::zero_clear_cond:       o_pass = !z;
			addr_mode_cond_decode_pkg::carry_set_cond:        o_pass = c;
			addr_mode_cond_decode_pkg::carry_clear_cond:      o_pass = !c;
			addr_mode_cond_decode_pkg::negative_cond:         o_pass = n;
			addr_mode_cond_decode_pkg::nonneg_cond:           o_pass = !n;
			addr_mode_cond_decode_pkg::overflow_set_cond:     o_pass = v;
			addr_mode_cond_decode_pkg::overflow_clear_cond:   o_pass = !v;
			addr_mode_cond_decode_pkg::unsigned_above_cond:   o_pass = c && !z;
			addr_mode_cond_decode_pkg::unsigned_at_most_cond: o_pass = !c || z;
			addr_mode_cond_decode_pkg::signed_at_least_cond:  o_pass = (n == v);
			addr_mode_cond_decode_pkg::signed_below_cond:     o_pass = (n != v);
			addr_mode_cond_decode_pkg::signed_above_cond:     o_pass = !z && (n == v);
			addr_mode_cond_decode_pkg::signed_at_most_cond:   o_pass = z || (n != v);
			addr_mode_cond_decode_pkg::never_skip_cond:       o_pass = 1'b1;
			default:                                          o_pass = 1'b0;
		endcase
	end
endmodule : cond_check

/* core/operand_shifter.sv */
`timescale 1ns/1ns
// Barrel shifter; a distance of zero leaves value and carry unchanged for every kind but the rotate through carry.
module operand_shifter (
	shift_if.unit sh
);
	logic [32:0] wide;  // Result with the carry bit alongside.
	logic [4:0]  rot;   // Rotate distance modulo 32.

	// Each kind works on 33 bits so the last bit shifted out is the carry.
	always_comb begin
		wide = {sh.carry_in, sh.value};
		rot  = sh.amount[4:0];
		case (sh.kind)
			addr_mode_cond_decode_pkg::shift_left_logical: begin
				if (sh.amount > 8'h20) wide = 33'h0_0000_0000;
				else if (sh.amount != 8'h00) wide = {1'b0, sh.value} << sh.amount;
			end
			addr_mode_cond_decode_pkg::shift_right_logical: begin
				if (sh.amount > 8'h20) wide = 33'h0_0000_0000;
				else if (sh.amount != 8'h00) begin
					wide = {sh.value, 1'b0} >> sh.amount;
					wide = {wide[0], wide[32:1]};
				end
			end
			addr_mode_cond_decode_pkg::arith_right_shift: begin
				if (sh.amount != 8'h00) begin
					wide = 33'($signed({sh.value, 1'b0}) >>> ((sh.amount > 8'h20) ? 8'h20 : sh.amount));
					wide = {wide[0], wide[32:1]};
				end
			end
			addr_mode_cond_decode_pkg::rotate_right: begin
				if (sh.amount != 8'h00) begin
					wide[31:0] = (sh.value >> rot) | (sh.value << (6'h20 - {1'b0, rot}));
					wide[32]   = wide[31];
				end
			end
			// Rotate one place through carry.
			addr_mode_cond_decode_pkg::rotate_through_carry: begin
				wide = {sh.value[0], sh.carry_in, sh.value[31:1]};
			end
			default: wide = {sh.carry_in, sh.value};
		endcase
	end

	assign sh.result    = wide[31:0];
	assign sh.carry_out = wide[32];
endmodule : operand_shifter

/* core/shift_if.sv */
`timescale 1ns/1ns
// Carries one shift request and its answer between decoder and shifter.
interface shift_if;
	logic [31:0]                             value;      // Register to shift.
	logic [7:0]                              amount;     // Shift distance.
	addr_mode_cond_decode_pkg::shift_kind_t  kind;       // Shift kind.
	logic                                    carry_in;   // Current C flag.
	logic [31:0]                             result;     // Shifted value.
	logic                                    carry_out;  // Shifter carry.
	modport requester (output value, amount, kind, carry_in, input result, carry_out);
	modport unit (input value, amount, kind, carry_in, output result, carry_out);
endinterface : shift_if

/* testbench/addr_mode_cond_decode_monitor.sv */
`timescale 1ns/1ns
// Shadows the written code and flags and checks the condition result and bus waits.
module addr_mode_cond_decode_monitor (
	input  wire logic        i_clk_sys,          // System clock.
	input  wire logic        i_sys_rst,          // Synchronous reset.
	input  wire logic [5:0]  i_avs_address,      // Byte address.
	input  wire logic        i_avs_read,         // Read request.
	input  wire logic        i_avs_write,        // Write request.
	input  wire logic [31:0] i_avs_writedata,    // Write data.
	input  wire logic [3:0]  i_avs_byteenable,   // Write lanes.
	input  wire logic        o_avs_waitrequest,  // Stall.
	input  wire logic        o_cond_pass         // Condition result.
);
	logic [3:0] cond_q;   // Condition code last written.
	logic [3:0] flags_q;  // Flags last written.
	logic [1:0] quiet_q;  // Cycles since a write completed, saturating at three.
	wire        wr_done = i_avs_write && !o_avs_waitrequest;  // A write completes here.
	wire        settled = (quiet_q == 2'h3);  // The result has had time to follow.
	wire        fn = flags_q[3];  // Negative flag.
	wire        fz = flags_q[2];  // Zero flag.
	wire        fc = flags_q[1];  // Carry flag.
	wire        fv = flags_q[0];  // Overflow flag.
	wire        one = cond_q[2] ? (cond_q[1] ? fv : fn) : (cond_q[1] ? fc : fz);  // Tested flag.

	// Follows software writes so the result can be predicted without the design.
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			cond_q  <= 4'h0;
			flags_q <= 4'h0;
			quiet_q <= 2'h0;
		end else begin
			if (wr_done && i_avs_address == 6'h00 && i_avs_byteenable[3]) cond_q <= i_avs_writedata[31:28];
			if (wr_done && i_avs_address == 6'h04 && i_avs_byteenable[0]) flags_q <= i_avs_writedata[3:0];
			quiet_q <= wr_done ? 2'h0 : (settled ? quiet_q : quiet_q + 2'h1);
		end
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);

	sequence s_req; $rose(i_avs_read || i_avs_write); endsequence
	sequence s_one_wait; o_avs_waitrequest ##1 !o_avs_waitrequest; endsequence
	property p_one_wait; s_req |-> s_one_wait; endproperty
	property p_single; settled && cond_q < 4'h8 |-> o_cond_pass == (one ^ cond_q[0]); endproperty
	property p_hi; settled && cond_q == 4'h8 |-> o_cond_pass == (fc && !fz); endproperty
	property p_ge; settled && cond_q == 4'hA |-> o_cond_pass == (fn == fv); endproperty
	property p_lt; settled && cond_q == 4'hB |-> o_cond_pass == (fn != fv); endproperty
	property p_gt; settled && cond_q == 4'hC |-> o_cond_pass == (!fz && fn == fv); endproperty
	property p_al; settled && cond_q == 4'hE |-> o_cond_pass; endproperty
	property p_ls; settled && cond_q == 4'h9 |-> o_cond_pass == (!fc || fz); endproperty
	property p_le; settled && cond_q == 4'hD |-> o_cond_pass == (fz || fn != fv); endproperty

	a_one_wait: assert property (p_one_wait) else $error("wait state count wrong");
	a_single: assert property (p_single) else $error("single flag result wrong");
	a_hi: assert property (p_hi) else $error("unsigned above result wrong");
	a_ge: assert property (p_ge) else $error("signed at least result wrong");
	a_lt: assert property (p_lt) else $error("signed below result wrong");
	a_gt: assert property (p_gt) else $error("signed above result wrong");
	a_al: assert property (p_al) else $error("always code did not pass");
	a_ls: assert property (p_ls) else $error("unsigned at most result wrong");
	a_le: assert property (p_le) else $error("signed at most result wrong");
endmodule : addr_mode_cond_decode_monitor

bind addr_mode_cond_decode addr_mode_cond_decode_monitor u_monitor (
	.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_avs_address(i_avs_address),
	.i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
	.i_avs_byteenable(i_avs_byteenable), .o_avs_waitrequest(o_avs_waitrequest),
	.o_cond_pass(o_cond_pass));

/* testbench/tb_addr_mode_cond_decode.sv */
`timescale 1ns/1ns
// Drives the decoder over its register bus and compares decode results.
module tb_addr_mode_cond_decode;
	logic        i_clk_sys = 1'b0;   // 250 MHz clock.
	logic        i_sys_rst;          // Synchronous reset.
	logic [5:0]  i_avs_address;      // Bus address.
	logic        i_avs_read;         // Read request.
	logic        i_avs_write;        // Write request.
	logic [31:0] i_avs_writedata;    // Write data.
	logic [3:0]  i_avs_byteenable;   // Write lanes, all on.
	logic [31:0] o_avs_readdata;     // Read data.
	logic        o_avs_waitrequest;  // Bus stall.
	logic        o_cond_pass;        // Condition result.
	logic [31:0] rdata;              // Last read word.
	int          num_errors = 0;     // Mismatches.
	int          tests_run = 0;      // Comparisons.
	logic [1:0]  ld_tab [4] = '{2'h2, 2'h0, 2'h3, 2'h1};  // Load alias by {P,U}.
	logic [1:0]  st_tab [4] = '{2'h1, 2'h3, 2'h0, 2'h2};  // Store alias by {P,U}.
	logic [31:0] ba_tab [4] = '{32'hFFFF_FFFC, 32'h0, 32'hFFFF_FFF8, 32'h4};  // Start offsets.
	logic [31:0] sh_ins [7] = '{32'hE1A0_0082, 32'hE1A0_00A2, 32'hE1A0_00C2, 32'hE1A0_00E2,
		32'hE1A0_0062, 32'hE1A0_0312, 32'hE3A0_04FF};  // Operand two forms.
	logic [31:0] sh_exp [7] = '{32'h4, 32'h4000_0001, 32'hC000_0001, 32'h4000_0001,
		32'hC000_0001, 32'h20, 32'hFF00_0000};  // Their results.

	addr_mode_cond_decode uut (
		.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_avs_address(i_avs_address),
		.i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
		.i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
		.o_avs_waitrequest(o_avs_waitrequest), .o_cond_pass(o_cond_pass));

	// Toggles the clock every half period.
	always #2 i_clk_sys = ~i_clk_sys;

	// Prints the counts and the verdict, then stops.
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run

	// Compares one value and counts it.
	task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : check

	// One bus access; the request holds until waitrequest is seen low.
	task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d,
			output logic [31:0] q);
		int n;
		n = 0;
		@(posedge i_clk_sys);
		i_avs_address <= a;
		i_avs_writedata <= d;
		i_avs_write <= w;
		i_avs_read <= !w;
		do begin
			@(posedge i_clk_sys);
			n++;
			if (n > 16) begin
				num_errors++;
				complete_run();
			end
		end while (o_avs_waitrequest !== 1'b0);
		q = o_avs_readdata;
		i_avs_write <= 1'b0;
		i_avs_read <= 1'b0;
	endtask : acc

	// Loads an instruction, reads one result word and compares the masked bits.
	task automatic dec(input logic [31:0] ins, input logic [5:0] a, input logic [31:0] m,
			input logic [31:0] e);
		logic [31:0] q;
		acc(1'b1, 6'h00, ins, q);
		acc(1'b0, a, 32'h0, q);
		check($sformatf("word %h of %h", a, ins), q & m, e);
	endtask : dec

	// Expected condition outcome for a code and flags N, Z, C, V.
	function automatic logic cond_exp(input logic [3:0] c, input logic [3:0] f);
		logic [15:0] t;
		t = {1'b0, 1'b1, f[2] || f[3] != f[0], !f[2] && f[3] == f[0], f[3] != f[0],
			f[3] == f[0], !f[1] || f[2], f[1] && !f[2], !f[0], f[0], !f[3], f[3],
			!f[1], f[1], !f[2], f[2]};
		return t[c];
	endfunction : cond_exp

	// Main sequence.
	initial begin
		i_sys_rst = 1'b1;
		i_avs_address = 6'h00;
		i_avs_read = 1'b0;
		i_avs_write = 1'b0;
		i_avs_writedata = 32'h0;
		i_avs_byteenable = 4'hF;
		repeat (8) @(posedge i_clk_sys);
		i_sys_rst <= 1'b0;
		acc(1'b0, 6'h04, 32'h0, rdata);
		check("flags after reset", rdata, 32'h0);
		// Every condition code against every flag combination.
		for (int c = 0; c < 16; c++) begin
			for (int f = 0; f < 16; f++) begin
				acc(1'b1, 6'h04, {28'h0, f[3:0]}, rdata);
				dec({c[3:0], 28'h0}, 6'h18, 32'h1,
					{31'h0, cond_exp(c[3:0], f[3:0])});
				check("o_cond_pass", {31'h0, o_cond_pass},
					{31'h0, cond_exp(c[3:0], f[3:0])});
			end
		end
		// Base, index, shift amount, carry set, user privilege.
		acc(1'b1, 6'h10, 32'h100, rdata);
		acc(1'b1, 6'h08, 32'h8000_0002, rdata);
		acc(1'b1, 6'h0C, 32'h4, rdata);
		acc(1'b1, 6'h04, 32'h2, rdata);
		acc(1'b1, 6'h14, 32'h1, rdata);
		for (int i = 0; i < 7; i++) dec(sh_ins[i], 6'h1C, 32'hFFFF_FFFF, sh_exp[i]);
		dec(32'hE1A0_0062, 6'h18, 32'h2000, 32'h0);
		dec(32'hE5B1_0FFF, 6'h18, 32'h2, 32'h0);
		dec(32'hE491_0FFF, 6'h24, 32'hFFFF_FFFF, 32'h10FF);
		dec(32'hE711_0102, 6'h20, 32'hFFFF_FFFF, 32'hF8);
		dec(32'hE171_0ABB, 6'h20, 32'hFFFF_FFFF, 32'h55);
		dec(32'hE171_0ABB, 6'h18, 32'h6, 32'h6);
		dec(32'hE091_00B2, 6'h24, 32'hFFFF_FFFF, 32'h8000_0102);
		dec(32'hED11_0080, 6'h20, 32'hFFFF_FFFF, 32'hFFFF_FF00);
		dec(32'hECA1_00FF, 6'h24, 32'hFFFF_FFFF, 32'h4FC);
		// All four sequences for loads and stores.
		for (int k = 0; k < 8; k++) begin
			dec({4'hE, 3'b100, k[1], k[0], 2'b00, k[2], 4'h1, 16'h0003}, 6'h18, 32'h0001_C1E0,
				{15'h0, 3'h4, 5'h0, k[2] ? ld_tab[k[1:0]] : st_tab[k[1:0]], k[1:0], 5'h0});
			dec({4'hE, 3'b100, k[1], k[0], 2'b00, k[2], 4'h1, 16'h0003}, 6'h20, 32'hFFFF_FFFF,
				32'h100 + ba_tab[k[1:0]]);
		end
		dec(32'hE891_0003, 6'h28, 32'hFFFF_FFFF, 32'h8);
		for (int i = 0; i < 4; i++) dec({12'hE12, 4'h1 << i, 16'hF000}, 6'h18, 32'h0001_DE00,
			{15'h0, 3'h6, 1'b0, 4'h8 >> i, 9'h0});
		// Unmapped place ignores writes and reads zero.
		acc(1'b1, 6'h2C, 32'hFFFF_FFFF, rdata);
		acc(1'b0, 6'h2C, 32'h0, rdata);
		check("unmapped word", rdata, 32'h0);
		complete_run();
	end
endmodule : tb_addr_mode_cond_decode
